// >>> tb/ssp_ext_master.sv
`timescale 1ns/1ps
// ==========================================
// External synchronous master: makes the link clock, idle low
module ssp_ext_master #(
  parameter realtime HALF = 100.0
) (
  output logic link_clk,
  output logic link_data,
  input wire logic slave_data
);
  initial begin
    link_clk = 1'b0;
    link_data = 1'b1;
  end

  // change on rise, n clocks, LSB first
  task automatic send_word(input logic [8:0] w, input int n);
    // Keep pin changes clear of the system clock edges
    #5.0;
    for (int i = 0; i < n; i++) begin
      #HALF;
      link_clk = 1'b1;
      link_data = w[i];
      #HALF;
      link_clk = 1'b0;
    end
    // Hold ends: released line shows the inverse, not a kind last value
    #HALF;
    link_data = ~link_data;
    #HALF;
  endtask

  // n clocks, LSB first, read on trailing edge
  task automatic recv_word(input int n, output logic [8:0] w);
    w = '0;
    #(HALF + 5.0);
    for (int i = 0; i < n; i++) begin
      link_clk = 1'b1;
      #HALF;
      w[i] = slave_data;
      link_clk = 1'b0;
      #HALF;
    end
  endtask
endmodule

// >>> tb/tb_sync_slave_serial_port.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
  check_count++; \
  if ((gt) !== (ex)) begin \
    mismatches++; \
    $display("BAD %s exp %h got %h", nm, ex, gt); \
  end \
end
module tb_sync_slave_serial_port;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, snap;
  logic clock_line_out, clock_line_oe_n, data_line_out, data_line_oe_n;
  logic transmit_flag, receive_flag, wake_irq, m_clk, m_data, data_wire;
  logic [8:0] w;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] cfg_rx [7] = '{8'h80, 8'h90, 8'ha0, 8'h80, 8'h80, 8'h80, 8'h00};
  logic [7:0] cfg_tx [7] = '{8'h30, 8'h30, 8'h30, 8'h10, 8'hb0, 8'h20, 8'h30};
  logic cfg_oe [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [8:0] ov_word [3] = '{9'h011, 9'h122, 9'h033};

  // ==========================================
  // Clock, wire resolution, instances
  always #12.5 pclk = ~pclk;
  assign data_wire = data_line_oe_n ? m_data : data_line_out;

  ssp_sync_slave dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_line_pin(m_clk),
    .clock_line_out(clock_line_out), .clock_line_oe_n(clock_line_oe_n),
    .data_line_pin(data_wire), .data_line_out(data_line_out),
    .data_line_oe_n(data_line_oe_n), .transmit_flag(transmit_flag),
    .receive_flag(receive_flag), .wake_irq(wake_irq)
  );

  ssp_ext_master master (
    .link_clk(m_clk), .link_data(m_data), .slave_data(data_wire)
  );

  // ==========================================
  // Verdict and hang guard
  task end_sim;
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      end_sim();
    end
  end

  // ==========================================
  // APB master transfer; result in rd and err
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ==========================================
  // Test sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    edges(5);
    presetn <= 1'b1;
    apb(0, ssp_pkg::ADDR_TX_STA, 0); `CHK("tx status", 32'h2, rd)
    apb(0, ssp_pkg::ADDR_RX_STA, 0); `CHK("rx status", 32'h0, rd)
    apb(0, ssp_pkg::ADDR_IRQ_CTL, 0); `CHK("irq ctl", 32'h10, rd)
    apb(0, 12'h470, 0); `CHK("slverr", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(1, ssp_pkg::ADDR_TX_BUF, 32'h77);
    apb(0, ssp_pkg::ADDR_IRQ_CTL, 0); `CHK("dropped write", 32'h10, rd)
    for (int i = 0; i < 7; i++) begin
      apb(1, ssp_pkg::ADDR_RX_STA, {24'h0, cfg_rx[i]});
      apb(1, ssp_pkg::ADDR_TX_STA, {24'h0, cfg_tx[i]});
      edges(1);
      `CHK("data drive", cfg_oe[i], data_line_oe_n)
      `CHK("clock drive", 1'b1, clock_line_oe_n)
      `CHK("clock out", 1'b0, clock_line_out)
    end
    // Nine-bit transmit, two words queued
    apb(1, ssp_pkg::ADDR_RX_STA, 32'h80);
    apb(1, ssp_pkg::ADDR_TX_STA, 32'h71);
    apb(1, ssp_pkg::ADDR_IRQ_CTL, 32'h05);
    apb(1, ssp_pkg::ADDR_TX_BUF, 32'ha5);
    apb(1, ssp_pkg::ADDR_TX_BUF, 32'h3c);
    edges(2);
    `CHK("tx flag held", 1'b0, transmit_flag)
    `CHK("no tx wake", 1'b0, wake_irq)
    snap = data_line_out;
    edges(40);
    `CHK("no free shift", snap, data_line_out)
    apb(0, ssp_pkg::ADDR_TX_STA, 0); `CHK("shift busy", 32'h71, rd)
    master.recv_word(9, w); `CHK("tx word a", 9'h1a5, w)
    edges(3);
    `CHK("tx flag set", 1'b1, transmit_flag)
    `CHK("tx wake", 1'b1, wake_irq)
    master.recv_word(9, w); `CHK("tx word b", 9'h13c, w)
    edges(8);
    apb(0, ssp_pkg::ADDR_TX_STA, 0); `CHK("shift empty", 32'h73, rd)
    apb(1, ssp_pkg::ADDR_TX_STA, 32'h30);
    apb(1, ssp_pkg::ADDR_TX_BUF, 32'h5a);
    master.recv_word(8, w); `CHK("tx byte", 9'h05a, w)
    // Receive, single enable set as well
    apb(1, ssp_pkg::ADDR_TX_STA, 32'h10);
    apb(1, ssp_pkg::ADDR_IRQ_CTL, 32'h06);
    apb(1, ssp_pkg::ADDR_RX_STA, 32'hf0);
    edges(2);
    `CHK("masked wake", 1'b0, wake_irq)
    master.send_word(9'h1c3, 9);
    edges(2);
    `CHK("rx flag", 1'b1, receive_flag)
    `CHK("rx wake", 1'b1, wake_irq)
    master.send_word(9'h03c, 9);
    apb(0, ssp_pkg::ADDR_RX_STA, 0); `CHK("ninth a", 1'b1, rd[0])
    apb(0, ssp_pkg::ADDR_RX_BUF, 0); `CHK("rx a", 32'hc3, rd)
    edges(1);
    `CHK("rx flag kept", 1'b1, receive_flag)
    apb(0, ssp_pkg::ADDR_RX_STA, 0); `CHK("ninth b", 1'b0, rd[0])
    apb(0, ssp_pkg::ADDR_RX_BUF, 0); `CHK("rx b", 32'h3c, rd)
    edges(1);
    `CHK("rx flag clear", 1'b0, receive_flag)
    apb(0, ssp_pkg::ADDR_RX_BUF, 0); `CHK("rx empty", 32'h0, rd)
    // Overrun and its clearing
    for (int i = 0; i < 3; i++) master.send_word(ov_word[i], 9);
    apb(0, ssp_pkg::ADDR_RX_STA, 0); `CHK("overrun", 1'b1, rd[1])
    master.send_word(9'h0ee, 9);
    apb(1, ssp_pkg::ADDR_RX_STA, 32'hc0);
    apb(0, ssp_pkg::ADDR_RX_STA, 0); `CHK("overrun gone", 1'b0, rd[1])
    apb(0, ssp_pkg::ADDR_RX_BUF, 0); `CHK("kept a", 32'h11, rd)
    apb(0, ssp_pkg::ADDR_RX_STA, 0); `CHK("kept ninth", 1'b1, rd[0])
    apb(0, ssp_pkg::ADDR_RX_BUF, 0); `CHK("kept b", 32'h22, rd)
    apb(0, ssp_pkg::ADDR_RX_BUF, 0); `CHK("no third", 32'h0, rd)
    apb(1, ssp_pkg::ADDR_RX_STA, 32'hd0);
    master.send_word(9'h055, 9);
    edges(2);
    `CHK("rx again", 1'b1, receive_flag)
    apb(1, ssp_pkg::ADDR_RX_STA, 32'h40);
    edges(2);
    `CHK("port reset", 1'b0, receive_flag)
    apb(0, ssp_pkg::ADDR_RX_BUF, 0); `CHK("flushed", 32'h0, rd)
    end_sim();
  end
endmodule

// >>> verilog/ssp_pkg.sv
package ssp_pkg;
  // ==========================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_RX_BUF = 10'h119;
  localparam logic [9:0] IDX_TX_BUF = 10'h11a;
  localparam logic [9:0] IDX_RX_STA = 10'h11d;
  localparam logic [9:0] IDX_TX_STA = 10'h11e;
  localparam logic [9:0] IDX_IRQ_CTL = 10'h120;
  localparam logic [11:0] ADDR_RX_BUF = {IDX_RX_BUF, 2'b00};
  localparam logic [11:0] ADDR_TX_BUF = {IDX_TX_BUF, 2'b00};
  localparam logic [11:0] ADDR_RX_STA = {IDX_RX_STA, 2'b00};
  localparam logic [11:0] ADDR_TX_STA = {IDX_TX_STA, 2'b00};
  localparam logic [11:0] ADDR_IRQ_CTL = {IDX_IRQ_CTL, 2'b00};

  // ==========================================
  // Receive status and control fields
  localparam int RXSTA_PORT_EN = 7;
  localparam int RXSTA_NINE_RX = 6;
  localparam int RXSTA_SINGLE_RX = 5;
  localparam int RXSTA_CONT_RX = 4;
  localparam int RXSTA_OVERRUN = 1;
  localparam int RXSTA_NINTH = 0;

  // ==========================================
  // Transmit status and control fields
  localparam int TXSTA_CLK_MASTER = 7;
  localparam int TXSTA_NINE_TX = 6;
  localparam int TXSTA_TX_EN = 5;
  localparam int TXSTA_SYNC = 4;
  localparam int TXSTA_SHIFT_EMPTY = 1;
  localparam int TXSTA_NINTH = 0;

  // ==========================================
  // Interrupt control fields
  localparam int IRQ_TX_EN = 0;
  localparam int IRQ_RX_EN = 1;
  localparam int IRQ_PERIPH_EN = 2;
  localparam int IRQ_TX_FLAG = 4;
  localparam int IRQ_RX_FLAG = 5;

  // ==========================================
  // Reset values and word sizes
  localparam logic CTRL_BIT_RESET = 1'b0;
  localparam logic DATA_LINE_IDLE = 1'b1;
  localparam logic [3:0] WORD_BITS_8 = 4'h8;
  localparam logic [3:0] WORD_BITS_9 = 4'h9;
  localparam int RX_FIFO_DEPTH = 2;
endpackage

// >>> verilog/ssp_sync_slave.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Slave when sync=1, clock master=0, enabled
// - Either receive enable selects receive direction
// - Shift clock from clock pin, driver off
// - Data changes leading edge, sampled trailing
// - Exactly one bit per clock cycle
// - Transmit needs enable; receive enables override
// - Ninth transmit bit is word MSB
// - First word loads at once, second waits
// - Emptied shift register reloads, flag sets
// - Transmit flag wakes when both enables set
// - Writing transmit buffer clears transmit flag
// - Drive data pin only while transmitting as slave
// - Continuous receive used, single receive ignored
// - Complete word moves to buffer, may wake
// - Receive flag sets on word completion
// - Ninth receive bit holds MSB
// - Overrun cleared by continuous enable or port
// - Reading buffer unloads, flag clears when empty
// - Only slave mode shifts during sleep
// - Shift registers step only on external clock edges
// - Port enable clear holds port in reset
module ssp_sync_slave #(
  parameter int RX_DEPTH = ssp_pkg::RX_FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clock_line_pin,
  output logic clock_line_out,
  output logic clock_line_oe_n,
  input wire logic data_line_pin,
  output logic data_line_out,
  output logic data_line_oe_n,
  output logic transmit_flag,
  output logic receive_flag,
  output logic wake_irq
);
  localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CW = $clog2(RX_DEPTH + 1);

  // ==========================================
  // Control bits
  logic port_enable, nine_bit_receive, single_receive_enable;
  logic continuous_receive_enable, clock_source_master;
  logic nine_bit_transmit, transmit_enable, sync_mode;
  logic transmit_ninth_bit, transmit_irq_enable, receive_irq_enable;
  logic peripheral_irq_enable, overrun_error;
  logic slave_mode, rx_dir, tx_active, rx_active, rx_run;

  assign slave_mode = port_enable & sync_mode & ~clock_source_master;
  assign rx_dir = single_receive_enable | continuous_receive_enable;
  assign tx_active = slave_mode & transmit_enable & ~rx_dir;
  assign rx_active = slave_mode & continuous_receive_enable;
  assign rx_run = rx_active & ~overrun_error;

  // ==========================================
  // APB decode
  logic setup, access, hit_rx, hit_tx, hit_rs, hit_ts, hit_irq, addr_ok;
  logic wr_tx_buf, rd_rx_buf;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit_rx = paddr == ssp_pkg::ADDR_RX_BUF;
  assign hit_tx = paddr == ssp_pkg::ADDR_TX_BUF;
  assign hit_rs = paddr == ssp_pkg::ADDR_RX_STA;
  assign hit_ts = paddr == ssp_pkg::ADDR_TX_STA;
  assign hit_irq = paddr == ssp_pkg::ADDR_IRQ_CTL;
  assign addr_ok = hit_rx | hit_tx | hit_rs | hit_ts | hit_irq;
  // Zero wait states: read data is captured in the setup cycle
  assign pready = access;
  assign pslverr = access & ~addr_ok;
  // Transmit buffer writes while the port is held in reset are dropped
  assign wr_tx_buf = access & pwrite & hit_tx & port_enable;
  assign rd_rx_buf = access & ~pwrite & hit_rx;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_enable <= ssp_pkg::CTRL_BIT_RESET;
      nine_bit_receive <= ssp_pkg::CTRL_BIT_RESET;
      single_receive_enable <= ssp_pkg::CTRL_BIT_RESET;
      continuous_receive_enable <= ssp_pkg::CTRL_BIT_RESET;
    end else if (access && pwrite && hit_rs) begin
      port_enable <= pwdata[ssp_pkg::RXSTA_PORT_EN];
      nine_bit_receive <= pwdata[ssp_pkg::RXSTA_NINE_RX];
      single_receive_enable <= pwdata[ssp_pkg::RXSTA_SINGLE_RX];
      continuous_receive_enable <= pwdata[ssp_pkg::RXSTA_CONT_RX];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_master <= ssp_pkg::CTRL_BIT_RESET;
      nine_bit_transmit <= ssp_pkg::CTRL_BIT_RESET;
      transmit_enable <= ssp_pkg::CTRL_BIT_RESET;
      sync_mode <= ssp_pkg::CTRL_BIT_RESET;
      transmit_ninth_bit <= ssp_pkg::CTRL_BIT_RESET;
    end else if (access && pwrite && hit_ts) begin
      clock_source_master <= pwdata[ssp_pkg::TXSTA_CLK_MASTER];
      nine_bit_transmit <= pwdata[ssp_pkg::TXSTA_NINE_TX];
      transmit_enable <= pwdata[ssp_pkg::TXSTA_TX_EN];
      sync_mode <= pwdata[ssp_pkg::TXSTA_SYNC];
      transmit_ninth_bit <= pwdata[ssp_pkg::TXSTA_NINTH];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_irq_enable <= ssp_pkg::CTRL_BIT_RESET;
      receive_irq_enable <= ssp_pkg::CTRL_BIT_RESET;
      peripheral_irq_enable <= ssp_pkg::CTRL_BIT_RESET;
    end else if (access && pwrite && hit_irq) begin
      transmit_irq_enable <= pwdata[ssp_pkg::IRQ_TX_EN];
      receive_irq_enable <= pwdata[ssp_pkg::IRQ_RX_EN];
      peripheral_irq_enable <= pwdata[ssp_pkg::IRQ_PERIPH_EN];
    end
  end

  // ==========================================
  // Pin synchronisers: a change counts once stages two and three agree
  logic ck_s1, ck_s2, ck_s3, ck_level, ck_rise, ck_fall;
  logic dt_s1, dt_s2, dt_s3, dt_level;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      ck_level <= 1'b0;
    end else begin
      ck_s1 <= clock_line_pin;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      if (ck_s2 == ck_s3) begin
        ck_level <= ck_s3;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
      dt_s3 <= 1'b0;
      dt_level <= 1'b0;
    end else begin
      dt_s1 <= data_line_pin;
      dt_s2 <= dt_s1;
      dt_s3 <= dt_s2;
      if (dt_s2 == dt_s3) begin
        dt_level <= dt_s3;
      end
    end
  end

  // shifting is paced only by edges of the external clock
  // Edge taken as soon as stages agree: the outgoing bit must settle
  // before the master's trailing edge, half a link period later
  assign ck_rise = ck_s2 & ck_s3 & ~ck_level;
  assign ck_fall = ~ck_s2 & ~ck_s3 & ck_level;

  assign clock_line_out = 1'b0;
  assign clock_line_oe_n = 1'b1;

  // ==========================================
  // Transmit path
  logic [7:0] transmit_buffer;
  logic tx_buf_full, tx_busy, tx_load, data_out;
  logic [8:0] transmit_shift_register;
  logic [3:0] tx_count;

  // a buffered word moves over at once when the shifter is free
  assign tx_load = tx_active & tx_buf_full & ~tx_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_buffer <= 8'h00;
      tx_buf_full <= 1'b0;
    end else if (!port_enable) begin
      tx_buf_full <= 1'b0;
    end else if (wr_tx_buf) begin
      transmit_buffer <= pwdata[7:0];
      tx_buf_full <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_shift_register <= 9'h000;
      tx_count <= 4'h0;
      tx_busy <= 1'b0;
      data_out <= ssp_pkg::DATA_LINE_IDLE;
    end else if (!port_enable) begin
      tx_count <= 4'h0;
      tx_busy <= 1'b0;
      data_out <= ssp_pkg::DATA_LINE_IDLE;
    end else if (tx_load) begin
      // ninth bit on top of buffered byte
      transmit_shift_register <= {transmit_ninth_bit, transmit_buffer};
      tx_count <= nine_bit_transmit ? ssp_pkg::WORD_BITS_9
                                    : ssp_pkg::WORD_BITS_8;
      tx_busy <= 1'b1;
    end else if (ck_rise && tx_busy && tx_active) begin
      data_out <= transmit_shift_register[0];
      transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
      tx_count <= 4'(tx_count - 4'h1);
      if (tx_count == 4'h1) begin
        tx_busy <= 1'b0;
      end
    end
  end

  assign data_line_out = data_out;
  assign data_line_oe_n = ~tx_active;
  // flag rises when the buffer empties
  assign transmit_flag = ~tx_buf_full;

  // ==========================================
  // Receive path
  logic [8:0] receive_shift_register, rx_word;
  logic [3:0] rx_count, rx_last;
  logic rx_done, rx_push, rx_pop, rx_full;
  logic [8:0] rx_mem [RX_DEPTH];
  logic [PW-1:0] rx_wr_ptr, rx_rd_ptr;
  logic [CW-1:0] rx_fill;

  assign rx_last = nine_bit_receive ? 4'(ssp_pkg::WORD_BITS_9 - 4'h1)
                                    : 4'(ssp_pkg::WORD_BITS_8 - 4'h1);
  // word complete on final trailing edge
  assign rx_done = ck_fall & rx_run & (rx_count == rx_last);
  assign rx_full = rx_fill == CW'(RX_DEPTH);
  assign rx_push = rx_done & ~rx_full;
  assign rx_pop = rd_rx_buf & (rx_fill != '0);

  always_comb begin
    rx_word = receive_shift_register;
    rx_word[rx_count] = dt_level;
    if (!nine_bit_receive) begin
      rx_word[8] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_shift_register <= 9'h000;
      rx_count <= 4'h0;
    end else if (!rx_run) begin
      rx_count <= 4'h0;
    end else if (ck_fall) begin
      receive_shift_register <= rx_word;
      if (rx_count == rx_last) begin
        rx_count <= 4'h0;
      end else begin
        rx_count <= 4'(rx_count + 4'h1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_fill <= '0;
    end else if (!port_enable) begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_fill <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_ptr <= (rx_wr_ptr == PW'(RX_DEPTH - 1)) ? '0
                                                      : PW'(rx_wr_ptr + 1'b1);
      end
      if (rx_pop) begin
        rx_rd_ptr <= (rx_rd_ptr == PW'(RX_DEPTH - 1)) ? '0
                                                      : PW'(rx_rd_ptr + 1'b1);
      end
      if (rx_push && !rx_pop) begin
        rx_fill <= CW'(rx_fill + 1'b1);
      end else if (rx_pop && !rx_push) begin
        rx_fill <= CW'(rx_fill - 1'b1);
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (rx_push) begin
      rx_mem[rx_wr_ptr] <= rx_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error <= 1'b0;
    end else if (!port_enable || !continuous_receive_enable) begin
      overrun_error <= 1'b0;
    end else if (rx_done && rx_full) begin
      overrun_error <= 1'b1;
    end
  end

  assign receive_flag = rx_fill != '0;

  // wake on enabled transmit or receive flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_irq <= 1'b0;
    end else begin
      wake_irq <= peripheral_irq_enable &
                  ((transmit_irq_enable & transmit_flag) |
                   (receive_irq_enable & receive_flag));
    end
  end

  // ==========================================
  // Read data
  logic [31:0] read_mux;
  logic [8:0] rx_head;
  assign rx_head = (rx_fill != '0) ? rx_mem[rx_rd_ptr] : 9'h000;

  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit_rx) begin
      // low eight bits of the word
      read_mux[7:0] = rx_head[7:0];
    end else if (hit_tx) begin
      read_mux[7:0] = transmit_buffer;
    end else if (hit_rs) begin
      read_mux[ssp_pkg::RXSTA_PORT_EN] = port_enable;
      read_mux[ssp_pkg::RXSTA_NINE_RX] = nine_bit_receive;
      read_mux[ssp_pkg::RXSTA_SINGLE_RX] = single_receive_enable;
      read_mux[ssp_pkg::RXSTA_CONT_RX] = continuous_receive_enable;
      read_mux[ssp_pkg::RXSTA_OVERRUN] = overrun_error;
      read_mux[ssp_pkg::RXSTA_NINTH] = rx_head[8];
    end else if (hit_ts) begin
      read_mux[ssp_pkg::TXSTA_CLK_MASTER] = clock_source_master;
      read_mux[ssp_pkg::TXSTA_NINE_TX] = nine_bit_transmit;
      read_mux[ssp_pkg::TXSTA_TX_EN] = transmit_enable;
      read_mux[ssp_pkg::TXSTA_SYNC] = sync_mode;
      read_mux[ssp_pkg::TXSTA_SHIFT_EMPTY] = ~tx_busy;
      read_mux[ssp_pkg::TXSTA_NINTH] = transmit_ninth_bit;
    end else if (hit_irq) begin
      read_mux[ssp_pkg::IRQ_TX_EN] = transmit_irq_enable;
      read_mux[ssp_pkg::IRQ_RX_EN] = receive_irq_enable;
      read_mux[ssp_pkg::IRQ_PERIPH_EN] = peripheral_irq_enable;
      read_mux[ssp_pkg::IRQ_TX_FLAG] = transmit_flag;
      read_mux[ssp_pkg::IRQ_RX_FLAG] = receive_flag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= read_mux;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_clock_driver_off: assert property (
    clock_line_oe_n && !clock_line_out)
    else $error("clock pin driver enabled");

  chk_data_drive_dir: assert property (
    !data_line_oe_n |-> slave_mode && transmit_enable && !rx_dir)
    else $error("data pin driven outside slave transmit");

  chk_tx_change_lead: assert property (
    port_enable && $changed(data_line_out) |-> $past(ck_rise))
    else $error("data changed away from a leading edge");

  chk_one_bit_shift: assert property (
    ck_rise && tx_busy && tx_active && port_enable
      |=> tx_count == 4'($past(tx_count) - 4'h1))
    else $error("shift did not move exactly one bit");

  chk_ninth_on_load: assert property (
    tx_load && port_enable |=> transmit_shift_register[8] ==
      $past(transmit_ninth_bit) && tx_count == (nine_bit_transmit ?
      ssp_pkg::WORD_BITS_9 : ssp_pkg::WORD_BITS_8))
    else $error("ninth transmit bit or length wrong on load");

  chk_reload_on_empty: assert property (
    tx_load && !wr_tx_buf |=> tx_busy && transmit_flag)
    else $error("pending word not moved into shifter");

  chk_write_clears_tf: assert property (
    wr_tx_buf |=> !transmit_flag ##1 tx_busy || !tx_active)
    else $error("transmit write did not clear flag");

  chk_rx_flag_set: assert property (
    rx_push |=> receive_flag)
    else $error("receive flag not set after word");

  chk_overrun_clear: assert property (
    !continuous_receive_enable |=> !overrun_error)
    else $error("overrun not cleared");

  chk_single_ignored: assert property (
    !continuous_receive_enable |=> rx_count == 4'h0)
    else $error("receiver ran without continuous enable");

  chk_port_reset: assert property (
    !port_enable |=> !tx_busy && !receive_flag && tx_count == 4'h0)
    else $error("port state not held in reset");

  chk_pop_to_empty: assert property (
    rx_pop && rx_fill == CW'(1) && !rx_push |=> !receive_flag)
    else $error("receive flag stayed after last read");

  cov_tx_word: cover property (tx_busy ##1 !tx_busy && tx_active);
  cov_rx_word: cover property (rx_push && nine_bit_receive);
  cov_overrun: cover property (rx_done && rx_full);
  cov_wake: cover property (!wake_irq ##1 wake_irq);
endmodule
